// >>> pkg/rlpm_regs.vh
// Purpose: Constants for the strap-latched peripheral pin mux
// Assumes: Straps sampled while i_rst_n is low
// Notes:   Default strap levels are the pulled-down values
`ifndef RLPM_REGS_VH
`define RLPM_REGS_VH
`define RLPM_ATM_DEFAULT      1'h0
`define RLPM_PCI_DEFAULT      1'h0
`define RLPM_AUTOINIT_DEFAULT 1'h0
`define RLPM_UGPIO_W          7
`define RLPM_UGPIO_LSB        9
`define RLPM_SYNC_W           3
`endif

// >>> verilog/rlpm_sync.v
// Purpose: Three-stage synchroniser with agreement filter for a pin input
// Assumes: Single clock i_clock
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
`include "rlpm_regs.vh"
module rlpm_sync (
  input  wire i_clock,
  input  wire i_rst_n,
  input  wire i_pin,
  output reg  o_level
);
  reg [`RLPM_SYNC_W-1:0] stage_r;

  // Shift chain; first stage is read only by the second
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      stage_r <= 3'h0;
      o_level <= 1'h0;
    end else begin
      stage_r <= {stage_r[1:0], i_pin};
      if (stage_r[1] == stage_r[2]) begin
        o_level <= stage_r[2];
      end
    end
  end
endmodule
`default_nettype wire

// >>> verilog/rlpm_mux.v
// Purpose: Strap-latched ownership of shared peripheral pins
// Assumes: Synchronous active-low reset; straps are steady while reset is low
// Notes:   Output enables high mean the owning block may drive the pin
// Contract
// - Sample all selection straps while reset is asserted; derive ownership from them.
// - ATM strap low: serial port 1 owns shared pins, ATM-only pins tri-stated.
// - ATM strap high: ATM port owns shared pins, serial-1-only pins tri-stated.
// - PCI strap low: host port enabled, upper GPIO usable once configured.
// - PCI off: byte enable 0 and EEPROM chip select pins tri-stated.
// - PCI strap high: host port off, all shared pins given to PCI.
// - Serial port 2 disabled only when PCI is 1 and serial2 select is 0.
// - PCI on, serial 2 off, autoinit strap 1: run EEPROM auto-init at reset.
// - After reset follow live serial2 select; high enables serial 2, stops EEPROM.
// - Default shared-pin functions are host port, serial port 2, unconnected.
// - Serial 2 clock pin is clock source unless GPIO8 enable and direction set.
// - Timers, serial port 0 and GPIO 8..0 always available.
// - Only one owner of each shared pin is active.
// - Autoinit 1 configures PCI from EEPROM; 0 uses built-in defaults.
`timescale 1ns/1ns
`default_nettype none
`include "rlpm_regs.vh"
module rlpm_mux (
  input  wire                     i_clock,
  input  wire                     i_rst_n,
  input  wire                     i_atm_select_strap_pin,
  input  wire                     i_pci_select_pin,
  input  wire                     i_serial2_select,
  input  wire                     i_autoinit_strap_pin,
  input  wire                     i_gpio8_enable_bit,
  input  wire                     i_gpio8_direction_bit,
  input  wire [`RLPM_UGPIO_W-1:0] i_gpio_enable_bits,
  input  wire [`RLPM_UGPIO_W-1:0] i_gpio_direction_bits,
  output reg                      o_serial1_owns_shared,
  output reg                      o_atm_owns_shared,
  output reg                      o_atm_only_oe,
  output reg                      o_serial1_only_oe,
  output reg                      o_host_port_enable,
  output reg                      o_pci_enable,
  output reg                      o_pci_only_oe,
  output reg  [`RLPM_UGPIO_W-1:0] o_upper_gpio_oe,
  output reg  [`RLPM_UGPIO_W-1:0] o_upper_gpio_owned,
  output reg                      o_serial2_enable,
  output reg                      o_eeprom_path_enable,
  output reg                      o_autoinit_start,
  output reg                      o_pci_use_defaults,
  output reg                      o_serial2_clock_is_source,
  output reg                      o_gpio8_output,
  output reg                      o_always_on_enable,
  output reg                      o_pci_pins_unconnected
);
  // Latched strap state, frozen from reset release until the next reset
  reg                      atm_select_r;
  reg                      pci_select_r;
  reg                      autoinit_r;
  reg                      in_reset_r;
  reg                      autoinit_done_r;

  // Strap and select levels after the pin synchronisers
  wire                     atm_sync;
  wire                     pci_sync;
  wire                     s2_sync;
  wire                     aut_sync;

  // Decoded next values of the registered outputs
  reg                      serial2_on_nxt;
  reg                      eeprom_path_nxt;
  reg                      autoinit_start_nxt;
  reg                      gpio8_out_nxt;
  wire [`RLPM_UGPIO_W-1:0] ugpio_owned_nxt;
  wire [`RLPM_UGPIO_W-1:0] ugpio_oe_nxt;
  genvar                   g;

  // Serial 2 loses its pins only with PCI latched on and select low
  function f_serial2_blocked;
    input pci_on;
    input s2_level;
    begin
      f_serial2_blocked = pci_on && !s2_level;
    end
  endfunction

  // GPIO line left to software only while PCI is latched off
  function f_host_gpio;
    input pci_on;
    input enable;
    begin
      f_host_gpio = !pci_on && enable;
    end
  endfunction

  // GPIO line drives out only with enable and direction both set
  function f_gpio_drives;
    input enable;
    input direction;
    begin
      f_gpio_drives = enable && direction;
    end
  endfunction

  // Strap pins into the clock domain
  // Chains never reset, so they track the board levels during reset
  rlpm_sync u_atm (
    .i_clock (i_clock),
    .i_rst_n (1'h1),
    .i_pin   (i_atm_select_strap_pin),
    .o_level (atm_sync)
  );

  rlpm_sync u_pci (
    .i_clock (i_clock),
    .i_rst_n (1'h1),
    .i_pin   (i_pci_select_pin),
    .o_level (pci_sync)
  );

  // Serial 2 select also decides auto-init at release
  // Chain left unreset so the level is known while reset is held
  rlpm_sync u_s2 (
    .i_clock (i_clock),
    .i_rst_n (1'h1),
    .i_pin   (i_serial2_select),
    .o_level (s2_sync)
  );

  rlpm_sync u_aut (
    .i_clock (i_clock),
    .i_rst_n (1'h1),
    .i_pin   (i_autoinit_strap_pin),
    .o_level (aut_sync)
  );

  // Sample straps each cycle of reset, freeze at release
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      atm_select_r <= atm_sync;
      pci_select_r <= pci_sync;
      autoinit_r   <= aut_sync;
      in_reset_r   <= 1'h1;
    end else begin
      in_reset_r   <= 1'h0;
    end
  end

  // Serial 2 follows live select; EEPROM path and start pulse decode
  always @* begin
    serial2_on_nxt     = !f_serial2_blocked(pci_select_r, s2_sync);
    eeprom_path_nxt    = f_serial2_blocked(pci_select_r, s2_sync) &&
                         autoinit_r;
    autoinit_start_nxt = in_reset_r && !autoinit_done_r &&
                         f_serial2_blocked(pci_select_r, s2_sync) &&
                         autoinit_r;
    gpio8_out_nxt      = f_gpio_drives(i_gpio8_enable_bit, i_gpio8_direction_bit);
  end

  // Per-line ownership of upper GPIO; PCI takes every line
  generate
    for (g = 0; g < `RLPM_UGPIO_W; g = g + 1) begin : gen_ugpio
      assign ugpio_owned_nxt[g] = f_host_gpio(pci_select_r, i_gpio_enable_bits[g]);
      assign ugpio_oe_nxt[g]    = f_gpio_drives(ugpio_owned_nxt[g],
                                                i_gpio_direction_bits[g]);
    end
  endgenerate

  // Auto-init pulse on the first cycle after release
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      autoinit_done_r  <= 1'h0;
      o_autoinit_start <= 1'h0;
    end else begin
      autoinit_done_r  <= 1'h1;
      o_autoinit_start <= autoinit_start_nxt;
    end
  end

  // Serial port 1 versus ATM port, exclusive owners
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_serial1_owns_shared <= 1'h1;
      o_atm_owns_shared     <= 1'h0;
      o_atm_only_oe         <= 1'h0;
      o_serial1_only_oe     <= 1'h0;
    end else begin
      o_serial1_owns_shared <= !atm_select_r;
      o_atm_owns_shared     <= atm_select_r;
      o_atm_only_oe         <= atm_select_r;
      o_serial1_only_oe     <= !atm_select_r;
    end
  end

  // Host port and upper GPIO versus PCI, fixed by the latched strap
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_host_port_enable     <= 1'h0;
      o_pci_enable           <= 1'h0;
      o_pci_only_oe          <= 1'h0;
      o_pci_pins_unconnected <= 1'h1;
      o_upper_gpio_owned     <= 7'h00;
      o_upper_gpio_oe        <= 7'h00;
    end else begin
      o_host_port_enable     <= !pci_select_r;
      o_pci_enable           <= pci_select_r;
      o_pci_only_oe          <= pci_select_r;
      o_pci_pins_unconnected <= !pci_select_r;
      o_upper_gpio_owned     <= ugpio_owned_nxt;
      o_upper_gpio_oe        <= ugpio_oe_nxt;
    end
  end

  // Serial port 2 versus EEPROM path, follows the live select
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_serial2_enable     <= 1'h0;
      o_eeprom_path_enable <= 1'h0;
      o_pci_use_defaults   <= 1'h1;
    end else begin
      o_serial2_enable     <= serial2_on_nxt;
      o_eeprom_path_enable <= eeprom_path_nxt;
      o_pci_use_defaults   <= !(pci_select_r && autoinit_r);
    end
  end

  // Clock source pin versus GPIO 8; always-on group never muxed
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_serial2_clock_is_source <= 1'h1;
      o_gpio8_output            <= 1'h0;
      o_always_on_enable        <= 1'h1;
    end else begin
      o_serial2_clock_is_source <= !gpio8_out_nxt;
      o_gpio8_output            <= gpio8_out_nxt;
      o_always_on_enable        <= 1'h1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/rlpm_mux_chk.sv
// Purpose: Port checks for the strap-latched pin mux
// Assumes: One clock, synchronous active-low reset
// Notes:   up_r counts edges since release, stops at 2
`timescale 1ns/1ns
`default_nettype none
module rlpm_mux_chk (
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  input wire logic       o_serial1_owns_shared,
  input wire logic       o_atm_owns_shared,
  input wire logic       o_atm_only_oe,
  input wire logic       o_serial1_only_oe,
  input wire logic       o_host_port_enable,
  input wire logic       o_pci_enable,
  input wire logic       o_pci_only_oe,
  input wire logic       o_serial2_enable,
  input wire logic       o_eeprom_path_enable,
  input wire logic       o_autoinit_start,
  input wire logic       o_pci_use_defaults,
  input wire logic       o_always_on_enable,
  input wire logic [6:0] i_gpio_enable_bits,
  input wire logic [6:0] o_upper_gpio_owned
);
  logic [1:0] up_r;
  // Edges since reset release
  always @(posedge i_clock) begin
    up_r <= !i_rst_n ? 2'h0 : (up_r == 2'h2 ? up_r : up_r + 2'h1);
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Start pulse with EEPROM path, gone next cycle
  sequence s_one_shot;
    o_autoinit_start && o_eeprom_path_enable ##1 !o_autoinit_start;
  endsequence
  a_atm_excl: assert property (o_atm_owns_shared != o_serial1_owns_shared)
    else $error("atm owner clash");
  a_atm_oe: assert property (up_r != 2'h0 |-> o_atm_only_oe == o_atm_owns_shared &&
    o_serial1_only_oe == o_serial1_owns_shared) else $error("atm oe wrong");
  a_pci_excl: assert property (up_r != 2'h0 |-> o_pci_enable != o_host_port_enable &&
    o_pci_only_oe == o_pci_enable) else $error("pci owner clash");
  a_straps_hold: assert property (up_r == 2'h2 |-> $stable(o_atm_owns_shared) &&
    $stable(o_pci_enable) && $stable(o_pci_use_defaults)) else $error("strap moved");
  a_gpio_own: assert property (up_r != 2'h0 |-> o_upper_gpio_owned ==
    (o_host_port_enable ? $past(i_gpio_enable_bits) : 7'h00)) else $error("gpio owner");
  a_serial2_on: assert property (up_r != 2'h0 && !o_pci_enable |-> o_serial2_enable)
    else $error("serial2 off");
  a_eeprom_excl: assert property (o_eeprom_path_enable |-> o_pci_enable &&
    !o_serial2_enable && !o_pci_use_defaults) else $error("eeprom path");
  a_init_pulse: assert property (o_autoinit_start |-> up_r == 2'h1 ##0 s_one_shot)
    else $error("init pulse");
  a_always_on: assert property (o_always_on_enable) else $error("always-on off");
endmodule
bind rlpm_mux rlpm_mux_chk u_rlpm_mux_chk (
  .i_clock              (i_clock),
  .i_rst_n              (i_rst_n),
  .o_serial1_owns_shared(o_serial1_owns_shared),
  .o_atm_owns_shared    (o_atm_owns_shared),
  .o_atm_only_oe        (o_atm_only_oe),
  .o_serial1_only_oe    (o_serial1_only_oe),
  .o_host_port_enable   (o_host_port_enable),
  .o_pci_enable         (o_pci_enable),
  .o_pci_only_oe        (o_pci_only_oe),
  .o_serial2_enable     (o_serial2_enable),
  .o_eeprom_path_enable (o_eeprom_path_enable),
  .o_autoinit_start     (o_autoinit_start),
  .o_pci_use_defaults   (o_pci_use_defaults),
  .o_always_on_enable   (o_always_on_enable),
  .i_gpio_enable_bits   (i_gpio_enable_bits),
  .o_upper_gpio_owned   (o_upper_gpio_owned)
);
`default_nettype wire

// >>> tb/rlpm_straps.sv
// Purpose: Board strap model for the pin mux
// Assumes: Bench picks the strap levels
// Notes:   Pins move just after a clock edge
`timescale 1ns/1ns
`default_nettype none
module rlpm_straps (
  input  wire logic       i_clock,
  input  wire logic [3:0] i_cfg,
  output logic      [3:0] o_pins
);
  // Straps driven to a valid level from the first clock edge on
  always @(posedge i_clock) o_pins <= i_cfg;
endmodule
`default_nettype wire

// >>> tb/test_rlpm_mux.sv
// Purpose: Bench for the strap-latched pin mux
// Assumes: Straps settle during the 10-cycle reset
// Notes:   Walks every strap combination
`timescale 1ns/1ns
`default_nettype none
module test_rlpm_mux;
  logic       i_clock = 1'h0, i_rst_n = 1'h0, i_gpio8_enable_bit = 1'h0;
  logic       i_gpio8_direction_bit = 1'h0, a, p, s, e;
  logic [6:0] i_gpio_enable_bits = 7'h00, i_gpio_direction_bits = 7'h33, en;
  logic [3:0] cfg = 4'h0;
  int         fail_count = 0, tests_run = 0;
  wire        i_atm_select_strap_pin, i_pci_select_pin, i_serial2_select, i_autoinit_strap_pin;
  wire        o_serial1_owns_shared, o_atm_owns_shared, o_atm_only_oe, o_serial1_only_oe;
  wire        o_host_port_enable, o_pci_enable, o_pci_only_oe, o_serial2_enable, o_gpio8_output;
  wire        o_eeprom_path_enable, o_autoinit_start, o_pci_use_defaults, o_always_on_enable;
  wire        o_serial2_clock_is_source, o_pci_pins_unconnected;
  wire [6:0]  o_upper_gpio_oe, o_upper_gpio_owned;
  rlpm_mux u_rlpm_mux (
    .i_clock                  (i_clock),
    .i_rst_n                  (i_rst_n),
    .i_atm_select_strap_pin   (i_atm_select_strap_pin),
    .i_pci_select_pin         (i_pci_select_pin),
    .i_serial2_select         (i_serial2_select),
    .i_autoinit_strap_pin     (i_autoinit_strap_pin),
    .i_gpio8_enable_bit       (i_gpio8_enable_bit),
    .i_gpio8_direction_bit    (i_gpio8_direction_bit),
    .i_gpio_enable_bits       (i_gpio_enable_bits),
    .i_gpio_direction_bits    (i_gpio_direction_bits),
    .o_serial1_owns_shared    (o_serial1_owns_shared),
    .o_atm_owns_shared        (o_atm_owns_shared),
    .o_atm_only_oe            (o_atm_only_oe),
    .o_serial1_only_oe        (o_serial1_only_oe),
    .o_host_port_enable       (o_host_port_enable),
    .o_pci_enable             (o_pci_enable),
    .o_pci_only_oe            (o_pci_only_oe),
    .o_upper_gpio_oe          (o_upper_gpio_oe),
    .o_upper_gpio_owned       (o_upper_gpio_owned),
    .o_serial2_enable         (o_serial2_enable),
    .o_eeprom_path_enable     (o_eeprom_path_enable),
    .o_autoinit_start         (o_autoinit_start),
    .o_pci_use_defaults       (o_pci_use_defaults),
    .o_serial2_clock_is_source(o_serial2_clock_is_source),
    .o_gpio8_output           (o_gpio8_output),
    .o_always_on_enable       (o_always_on_enable),
    .o_pci_pins_unconnected   (o_pci_pins_unconnected)
  );
  rlpm_straps u_rlpm_straps (.i_clock(i_clock), .i_cfg(cfg), .o_pins({i_atm_select_strap_pin,
    i_pci_select_pin, i_serial2_select, i_autoinit_strap_pin}));
  // Clock and watchdog
  always #5 i_clock = ~i_clock;
  initial begin
    #20000;
    fail_count++;
    results();
  end
  task automatic strap(input logic [3:0] c);
    @(posedge i_clock);
    cfg <= c;
  endtask
  task automatic chk(input string n, input logic [6:0] x, input logic [6:0] g);
    tests_run++;
    if (g !== x) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Every strap combination, each followed by late strap moves
  initial begin
    for (int k = 0; k < 16; k++) begin
      {a, p, s, e} = k[3:0];
      en = 7'h5A ^ {3'h0, k[3:0]};
      strap(k[3:0]);
      i_rst_n <= 1'h0;
      i_gpio_enable_bits <= en;
      {i_gpio8_enable_bit, i_gpio8_direction_bit} <= k[1:0];
      repeat (10) @(posedge i_clock);
      i_rst_n <= 1'h1;
      @(posedge i_clock);
      #1;
      chk("pulse", p & ~s & e, o_autoinit_start);
      chk("atm", {a, ~a, a, ~a}, {o_atm_owns_shared, o_serial1_owns_shared,
        o_atm_only_oe, o_serial1_only_oe});
      chk("pci", {p, ~p, p, ~p}, {o_pci_enable, o_host_port_enable,
        o_pci_only_oe, o_pci_pins_unconnected});
      chk("gpio", p ? 7'h00 : en, o_upper_gpio_owned);
      chk("gpoe", p ? 7'h00 : en & 7'h33, o_upper_gpio_oe);
      chk("gp8", {k[0] & k[1], ~(k[0] & k[1])},
        {o_gpio8_output, o_serial2_clock_is_source});
      chk("s2", {~(p & ~s), p & ~s & e, ~(p & e), 1'h1}, {o_serial2_enable,
        o_eeprom_path_enable, o_pci_use_defaults, o_always_on_enable});
      strap({~a, ~p, s, ~e});
      repeat (8) @(posedge i_clock);
      #1;
      chk("hold", {a, p, ~(p & e)}, {o_atm_owns_shared, o_pci_enable, o_pci_use_defaults});
      strap({~a, ~p, 1'h1, ~e});
      repeat (8) @(posedge i_clock);
      #1;
      chk("live", 7'h02, {o_serial2_enable, o_eeprom_path_enable});
    end
    results();
  end
endmodule
`default_nettype wire
